// ===== pwm_trio.sv
// Top of the general purpose PWM trio.
`include "pwm_trio_params.svh"
module pwm_trio
  import pwm_trio_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [`DUTY_W-1:0] fixed_pwm_a_control,
  input wire logic [`DUTY_W-1:0] fixed_pwm_b_control,
  input wire prog_pwm_timing_control_t prog_pwm_timing_control,
  input wire logic [2:0] invert_enable,
  output logic [2:0] pwm_pin_out,
  output logic [2:0] pwm_raw_out
);
  logic [2:0] raw;
  logic [2:0] pin_r;
  prog_pwm_timing_control_t cfg_r;
  prog_phase_t phase_r;
  logic [`PRESCALE_W-1:0] pre_r;
  logic [`COUNT_W-1:0] cnt_r;
  logic tick;
  logic [`DUTY_W-1:0] duty_in [2];
  logic prog_high_r;
  prog_phase_t load_phase;
  logic [`COUNT_W-1:0] load_count;
  logic high_last;
  logic low_last;
  logic period_end;
  logic reload;
  logic [`PERIOD_W-1:0] span_r;
  logic [`PERIOD_W-1:0] period_want;

  assign duty_in[0] = fixed_pwm_a_control;
  assign duty_in[1] = fixed_pwm_b_control;

  // Both fixed generators share one structure.
  for (genvar i = 0; i < 2; i++) begin : g_fixed
    fixed_pwm u_fixed (
      .clock(clock),
      .srst(srst),
      .fixed_pwm_duty_value(duty_in[i]),
      .pwm_out(raw[i])
    );
  end

  assign tick = (pre_r == cfg_r.prescale);

  always_ff @(posedge clock) begin
    if (srst || tick || phase_r == PHASE_IDLE) begin
      pre_r <= `PRESCALE_ZERO;
    end else begin
      pre_r <= pre_r + `PRESCALE_ONE;
    end
  end

  // A both-zero setting parks the generator idle, where the level sits low.
  always_comb begin
    load_phase = PHASE_IDLE;
    load_count = `COUNT_ZERO;
    if (prog_pwm_timing_control.high_count != `COUNT_ZERO) begin
      load_phase = PHASE_HIGH;
      load_count = prog_pwm_timing_control.high_count;
    end else if (prog_pwm_timing_control.low_count != `COUNT_ZERO) begin
      load_phase = PHASE_LOW;
      load_count = prog_pwm_timing_control.low_count;
    end
  end

  assign high_last = (phase_r == PHASE_HIGH) && tick && (cnt_r == `COUNT_ONE);
  assign low_last = (phase_r == PHASE_LOW) && tick && (cnt_r == `COUNT_ONE);

  // Reloading right at the period end keeps the low level exact, with no spare idle clock.
  assign period_end = low_last || (high_last && (cfg_r.low_count == `COUNT_ZERO));
  assign reload = (phase_r == PHASE_IDLE) || period_end;

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_r <= '0;
    end else if (reload) begin
      cfg_r <= prog_pwm_timing_control;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      phase_r <= PHASE_IDLE;
    end else if (reload) begin
      phase_r <= load_phase;
    end else if (tick) begin
      case (phase_r)
        PHASE_HIGH: begin
          if (cnt_r == `COUNT_ONE) begin
            phase_r <= PHASE_LOW;
          end
        end
        PHASE_LOW: begin
          phase_r <= PHASE_LOW;
        end
        default: begin
          phase_r <= PHASE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r <= `COUNT_ZERO;
    end else if (reload) begin
      cnt_r <= load_count;
    end else if (tick) begin
      case (phase_r)
        PHASE_HIGH: begin
          if (cnt_r == `COUNT_ONE) begin
            cnt_r <= cfg_r.low_count;
          end else begin
            cnt_r <= cnt_r - `COUNT_ONE;
          end
        end
        PHASE_LOW: begin
          cnt_r <= cnt_r - `COUNT_ONE;
        end
        default: begin
          cnt_r <= `COUNT_ZERO;
        end
      endcase
    end
  end

  // The level has a flop of its own, so the output is not a decode of the phase code.
  always_ff @(posedge clock) begin
    if (srst) begin
      prog_high_r <= 1'b0;
    end else if (reload) begin
      prog_high_r <= (load_phase == PHASE_HIGH);
    end else if (high_last || (phase_r != PHASE_HIGH)) begin
      prog_high_r <= 1'b0;
    end
  end

  assign raw[2] = prog_high_r;

  // Cycles since the period began, kept only for the period length check below.
  always_ff @(posedge clock) begin
    if (srst) begin
      span_r <= '0;
    end else if (reload) begin
      span_r <= `PERIOD_ONE;
    end else begin
      span_r <= span_r + `PERIOD_ONE;
    end
  end

  assign period_want = (`PERIOD_W'(cfg_r.high_count) + `PERIOD_W'(cfg_r.low_count))
    * (`PERIOD_W'(cfg_r.prescale) + `PERIOD_ONE);

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_r <= '0;
    end else begin
      pin_r <= raw ^ invert_enable;
    end
  end

  assign pwm_pin_out = pin_r;
  assign pwm_raw_out = raw;

  sequence s_high_last;
    (phase_r == PHASE_HIGH) && tick && (cnt_r == `COUNT_ONE);
  endsequence

  sequence s_low_last;
    (phase_r == PHASE_LOW) && tick && (cnt_r == `COUNT_ONE);
  endsequence

  sequence s_base_run;
    (phase_r != PHASE_IDLE) && !tick;
  endsequence

  sequence s_base_tick;
    (phase_r != PHASE_IDLE) && tick;
  endsequence

  a_prog_zero_low: assert property (@(posedge clock) disable iff (srst)
    (cfg_r.high_count == `COUNT_ZERO && cfg_r.low_count == `COUNT_ZERO) |-> !raw[2])
    else $error("programmable output high with zero counts");

  a_prog_zero_park: assert property (@(posedge clock) disable iff (srst)
    (reload && (load_phase == PHASE_IDLE)) |=> ((phase_r == PHASE_IDLE) && !raw[2]))
    else $error("programmable generator not parked low");

  a_prog_tick_base: assert property (@(posedge clock) disable iff (srst)
    s_base_tick |=> (pre_r == `PRESCALE_ZERO))
    else $error("prescaler did not restart");

  a_prog_base_step: assert property (@(posedge clock) disable iff (srst)
    s_base_run |=> (pre_r == $past(pre_r) + `PRESCALE_ONE))
    else $error("prescaler did not advance");

  a_prog_pre_bound: assert property (@(posedge clock) disable iff (srst)
    (phase_r != PHASE_IDLE) |-> (pre_r <= cfg_r.prescale))
    else $error("prescaler ran past its setting");

  a_prog_high_low: assert property (@(posedge clock) disable iff (srst)
    s_high_last ##0 (cfg_r.low_count != `COUNT_ZERO)
    |=> ((phase_r == PHASE_LOW) && (cnt_r == $past(cfg_r.low_count))))
    else $error("no high to low step");

  a_prog_count_down: assert property (@(posedge clock) disable iff (srst)
    ((phase_r == PHASE_LOW) && tick && (cnt_r != `COUNT_ONE))
    |=> (cnt_r == $past(cnt_r) - `COUNT_ONE)) else $error("low count did not step");

  a_prog_level_match: assert property (@(posedge clock) disable iff (srst)
    1'b1 |-> (raw[2] == (phase_r == PHASE_HIGH)))
    else $error("programmable level disagrees with phase");

  a_prog_period_len: assert property (@(posedge clock) disable iff (srst)
    period_end |-> (span_r == period_want))
    else $error("programmable period length wrong");

  a_prog_cfg_hold: assert property (@(posedge clock) disable iff (srst)
    ((phase_r != PHASE_IDLE) && !period_end) |=> $stable(cfg_r))
    else $error("settings changed mid period");

  a_prog_wrap_load: assert property (@(posedge clock) disable iff (srst)
    s_low_last |=> (cfg_r == $past(prog_pwm_timing_control)))
    else $error("settings not taken at period end");

  a_pin_invert: assert property (@(posedge clock) disable iff (srst)
    1'b1 |=> (pin_r == ($past(raw) ^ $past(invert_enable))))
    else $error("pin polarity wrong");
endmodule : pwm_trio

// ===== pwm_trio_params.svh
// Constants and rule summary for the general purpose PWM trio.
// Summary of operation
// - Three independent generators: two fixed-period, one programmable; each drives its own fixed pin.
// - Fixed generators run a constant 512-cycle period regardless of duty.
// - Fixed generator output is high for duty value out of 512 cycles.
// - Zero duty value holds the fixed generator output permanently low.
// - Programmable base period is prescale setting plus one oscillator cycles.
// - Programmable output high for high count bases, then low count bases.
// - High and low counts both zero force programmable output low.
// - Each output may be inverted before it drives its pin.
`ifndef PWM_TRIO_PARAMS_SVH
`define PWM_TRIO_PARAMS_SVH
`define FIXED_PERIOD_LAST 9'h1ff
`define FIXED_CNT_W 9
`define DUTY_W 10
`define PRESCALE_W 7
`define COUNT_W 8
`define PRESCALE_ZERO 7'h00
`define COUNT_ZERO 8'h00
`define COUNT_ONE 8'h01
`define DUTY_ZERO 10'h000
`define FIXED_CNT_ZERO 9'h000
`define FIXED_CNT_ONE 9'h001
`define PRESCALE_ONE 7'h01
`define PERIOD_W 16
`define PERIOD_ONE 16'h0001
`endif

// ===== pwm_trio_pkg.sv
// Types shared by the general purpose PWM trio.
`include "pwm_trio_params.svh"
package pwm_trio_pkg;
  typedef struct packed {
    logic [`PRESCALE_W-1:0] prescale;
    logic [`COUNT_W-1:0] high_count;
    logic [`COUNT_W-1:0] low_count;
  } prog_pwm_timing_control_t;
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_HIGH = 2'b01,
    PHASE_LOW = 2'b10
  } prog_phase_t;
endpackage : pwm_trio_pkg

// ===== fixed_pwm.sv
// One fixed-period auxiliary PWM generator.
`include "pwm_trio_params.svh"
module fixed_pwm
  import pwm_trio_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [`DUTY_W-1:0] fixed_pwm_duty_value,
  output logic pwm_out
);
  logic [`FIXED_CNT_W-1:0] cnt_r;
  logic [`DUTY_W-1:0] duty_r;
  logic pwm_r;
  logic [`DUTY_W:0] pos_ext;

  always_ff @(posedge clock) begin
    if (srst || cnt_r == `FIXED_PERIOD_LAST) begin
      cnt_r <= `FIXED_CNT_ZERO;
    end else begin
      cnt_r <= cnt_r + `FIXED_CNT_ONE;
    end
  end

  // Duty is taken only at wrap so a running period is never cut short.
  always_ff @(posedge clock) begin
    if (srst) begin
      duty_r <= `DUTY_ZERO;
    end else if (cnt_r == `FIXED_PERIOD_LAST) begin
      duty_r <= fixed_pwm_duty_value;
    end
  end

  assign pos_ext = {2'b00, cnt_r};

  // Values above 512 saturate at 100 percent high.
  always_ff @(posedge clock) begin
    if (srst) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= (duty_r != `DUTY_ZERO) && (pos_ext < {1'b0, duty_r});
    end
  end

  assign pwm_out = pwm_r;

  a_fixed_zero_low: assert property (@(posedge clock) disable iff (srst)
    (duty_r == `DUTY_ZERO) |=> !pwm_r) else $error("fixed pwm high at zero duty");
  a_fixed_wrap_period: assert property (@(posedge clock) disable iff (srst)
    (cnt_r == `FIXED_PERIOD_LAST) |=> (cnt_r == `FIXED_CNT_ZERO))
    else $error("fixed period wrap wrong");
  a_fixed_duty_load: assert property (@(posedge clock) disable iff (srst)
    (cnt_r != `FIXED_PERIOD_LAST) |=> $stable(duty_r)) else $error("duty changed mid period");
endmodule : fixed_pwm

// ===== pwm_pin_monitor.sv
// Pin-side model that times the pulses it sees on the three PWM pins.
module pwm_pin_monitor (
  input wire logic clock,
  input wire logic [2:0] pin,
  output logic [2:0][15:0] high_len,
  output logic [2:0][15:0] period_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] prev_r;
  logic [2:0][15:0] hi_r;
  logic [2:0][15:0] per_r;
  // Lengths latch on edges only, so a stuck pin leaves stale values behind.
  always_ff @(posedge clock) begin
    prev_r <= pin;
    for (int i = 0; i < 3; i++) begin
      per_r[i] <= (pin[i] && !prev_r[i]) ? 16'h0001 : per_r[i] + 16'h0001;
      hi_r[i] <= (pin[i] && !prev_r[i]) ? 16'h0001 : hi_r[i] + 16'h0001;
      if (pin[i] && !prev_r[i]) period_len[i] <= per_r[i];
      if (!pin[i] && prev_r[i]) high_len[i] <= hi_r[i];
    end
  end
endmodule : pwm_pin_monitor

// ===== pwm_trio_tb_top.sv
// Bench for the PWM trio: sets controls and times the pins.
module pwm_trio_tb_top;
  import pwm_trio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock;
  logic srst;
  logic [9:0] duty_a;
  logic [9:0] duty_b;
  prog_pwm_timing_control_t prog;
  logic [2:0] inv;
  logic [2:0] pin;
  logic [2:0] raw;
  logic [2:0][15:0] hl;
  logic [2:0][15:0] pl;
  int bad_count = 0;
  int n_compared = 0;
  pwm_trio i_pwm_trio (.clock(clock), .srst(srst), .fixed_pwm_a_control(duty_a),
    .fixed_pwm_b_control(duty_b), .prog_pwm_timing_control(prog),
    .invert_enable(inv), .pwm_pin_out(pin), .pwm_raw_out(raw));
  pwm_pin_monitor i_pwm_pin_monitor (.clock(clock), .pin(pin), .high_len(hl),
    .period_len(pl));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic hold_level(input int idx, input logic lvl);
    int seen;
    seen = 0;
    repeat (600) begin
      @(negedge clock);
      seen += (pin[idx] !== lvl);
    end
    check("pin level", 16'h0000, 16'(seen));
  endtask : hold_level
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    duty_a = 10'h100;
    duty_b = 10'h000;
    prog = '{7'h01, 8'h03, 8'h02};
    inv = 3'b000;
    repeat (5) @(negedge clock);
    srst = 1'b0;
    repeat (1300) @(negedge clock);
    check("a high", 16'h0100, hl[0]);
    check("a period", 16'h0200, pl[0]);
    check("prog high", 16'h0006, hl[2]);
    check("prog period", 16'h000a, pl[2]);
    hold_level(1, 1'b0);
    $display("test fixed and prog timing done");
    // Changed mid-period; the old duty and counts finish their period before the new ones start, but the new inversion reaches the pins one clock later.
    duty_a = 10'h000;
    duty_b = 10'h080;
    prog = '{7'h00, 8'h00, 8'h00};
    inv = 3'b111;
    repeat (1300) @(negedge clock);
    check("b inverted high", 16'h0180, hl[1]);
    check("b period", 16'h0200, pl[1]);
    hold_level(0, 1'b1);
    hold_level(2, 1'b1);
    $display("test zero and invert done");
    // A zero low count keeps the level high; a zero high count keeps it low.
    prog = '{7'h00, 8'h02, 8'h00};
    repeat (20) @(negedge clock);
    check("raw prog and a", 16'h0002, 16'({raw[2], raw[0]}));
    hold_level(2, 1'b0);
    prog = '{7'h00, 8'h00, 8'h03};
    repeat (20) @(negedge clock);
    hold_level(2, 1'b1);
    $display("test single level done");
    close_out();
  end
endmodule : pwm_trio_tb_top
